// file: rtl/tdl_map.svh
// Register indices, field positions, reset values and midcode levels of the trim DAC bank
`ifndef TDL_MAP_SVH
`define TDL_MAP_SVH
// Printed register indices; byte address is four times the index
`define TDL_IDX_CTRL_CH2 8'h51
`define TDL_IDX_CTRL_CH3 8'h52
`define TDL_IDX_CODE_CH2 8'h59
`define TDL_IDX_CODE_CH3 8'h5a
`define TDL_IDX_UPPER_CH2 8'h61
`define TDL_IDX_UPPER_CH3 8'h62
`define TDL_IDX_LOWER_CH2 8'h69
`define TDL_IDX_LOWER_CH3 8'h6a
`define TDL_IDX_STATUS 8'h70
// Control register fields
`define TDL_CTRL_ON_BIT 2
`define TDL_CTRL_SEL_LSB 0
// Status register: three bits per channel
`define TDL_STAT_DRIVE_BIT 0
`define TDL_STAT_CLAMP_HI_BIT 1
`define TDL_STAT_CLAMP_LO_BIT 2
`define TDL_STAT_STRIDE 4
// Reset values
`define TDL_RST_SEL 2'h0
`define TDL_RST_CODE 8'h7f
`define TDL_RST_UPPER 8'hff
`define TDL_RST_LOWER 8'h00
`define TDL_MIDCODE 8'h7f
// Midcode output level in millivolts per select code
`define TDL_MID_MV_SEL0 11'd1250
`define TDL_MID_MV_SEL1 11'd1000
`define TDL_MID_MV_SEL2 11'd800
`define TDL_MID_MV_SEL3 11'd600
`endif

// file: rtl/tdl_pkg.sv
// Types shared by the trim DAC register bank and its channel clamp
package tdl_pkg;
  typedef struct packed
  {
    logic on;
    logic [1:0] sel;
    logic [7:0] code;
    logic [7:0] upper;
    logic [7:0] lower;
  } tdl_chan_cfg_t;

  typedef struct packed
  {
    logic [7:0] applied;
    logic drive;
    logic [10:0] mid_mv;
    logic clamp_hi;
    logic clamp_lo;
  } tdl_chan_state_t;

  typedef struct packed
  {
    tdl_chan_cfg_t [1:0] ch;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
  } tdl_regs_state_t;
endpackage

// file: rtl/tdl_channel.sv
// One trim DAC channel: code clamp, output enable and midcode level decode
`timescale 1ns/1ps
`include "tdl_map.svh"
module tdl_channel
  import tdl_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire tdl_chan_cfg_t cfg_i,
  output logic [7:0] code_o,
  output logic drive_o,
  output logic [10:0] mid_mv_o,
  output logic clamp_hi_o,
  output logic clamp_lo_o
);
  tdl_chan_state_t s;
  tdl_chan_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.clamp_hi = cfg_i.code > cfg_i.upper;
    next_s.clamp_lo = cfg_i.code < cfg_i.lower;
    // Upper check first; only matters when limits are crossed, and then drive is off anyway
    if (cfg_i.code > cfg_i.upper)
    begin
      next_s.applied = cfg_i.upper;
    end
    else if (cfg_i.code < cfg_i.lower)
    begin
      next_s.applied = cfg_i.lower;
    end
    else
    begin
      next_s.applied = cfg_i.code;
    end
    next_s.drive = cfg_i.on && !(cfg_i.lower > cfg_i.upper);
    case (cfg_i.sel)
      2'h0: next_s.mid_mv = `TDL_MID_MV_SEL0;
      2'h1: next_s.mid_mv = `TDL_MID_MV_SEL1;
      2'h2: next_s.mid_mv = `TDL_MID_MV_SEL2;
      2'h3: next_s.mid_mv = `TDL_MID_MV_SEL3;
      default: next_s.mid_mv = `TDL_MID_MV_SEL0;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign code_o = s.applied;
  assign drive_o = s.drive;
  assign mid_mv_o = s.mid_mv;
  assign clamp_hi_o = s.clamp_hi;
  assign clamp_lo_o = s.clamp_lo;
endmodule

// file: rtl/tdl_regs.sv
// AHB-Lite register bank for trim DAC channels 2 and 3 with code clamping
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "tdl_map.svh"
// Behaviour
// - Midcode select 00,01,10,11 chooses 1.25 V, 1.0 V, 0.8 V, 0.6 V.
// - Each channel holds an 8-bit read/write code; 0x7F means midcode level.
// - Stored code above upper limit applies the upper limit instead.
// - Stored code below lower limit and not above upper limit applies the lower limit instead.
// - Output stays disabled while lower limit exceeds upper limit.
// - Control bit 2 enables the channel; output driven only while set.
// - Code within limits inclusive passes unchanged; otherwise the violated limit applies.
module tdl_regs
  import tdl_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [7:0] ch2_code_o,
  output logic ch2_drive_o,
  output logic [10:0] ch2_mid_mv_o,
  output logic [7:0] ch3_code_o,
  output logic ch3_drive_o,
  output logic [10:0] ch3_mid_mv_o
);
  tdl_regs_state_t s;
  tdl_regs_state_t next_s;
  logic [1:0] drive;
  logic [1:0] clamp_hi;
  logic [1:0] clamp_lo;
  logic [7:0] code [2];
  logic [10:0] mid_mv [2];
  logic take;
  logic [7:0] addr_idx;
  logic [7:0] status;

  // Only word transfers are expected; narrower sizes still act on the low byte
  assign take = hsel_i && htrans_i[1] && hready_i;
  // Addresses outside the block's 1 KiB window, or unaligned, map to index 0 (unmapped)
  assign addr_idx = (haddr_i[31:10] == 22'h0 && haddr_i[1:0] == 2'h0) ? haddr_i[9:2] : 8'h00;

  function automatic logic [7:0] status_byte(input logic [1:0] drv, input logic [1:0] hi,
                                             input logic [1:0] lo);
    logic [7:0] v;
    v = 8'h00;
    for (int c = 0; c < 2; c++)
    begin
      v[c * `TDL_STAT_STRIDE + `TDL_STAT_DRIVE_BIT] = drv[c];
      v[c * `TDL_STAT_STRIDE + `TDL_STAT_CLAMP_HI_BIT] = hi[c];
      v[c * `TDL_STAT_STRIDE + `TDL_STAT_CLAMP_LO_BIT] = lo[c];
    end
    return v;
  endfunction

  assign status = status_byte(drive, clamp_hi, clamp_lo);

  // Read mux; bits above each register's width read zero
  function automatic logic [31:0] read_word(input logic [7:0] idx,
                                            input tdl_chan_cfg_t [1:0] ch,
                                            input logic [7:0] stat);
    logic [31:0] w;
    w = 32'h0;
    case (idx)
      `TDL_IDX_CTRL_CH2:
      begin
        w[`TDL_CTRL_ON_BIT] = ch[0].on;
        w[`TDL_CTRL_SEL_LSB +: 2] = ch[0].sel;
      end
      `TDL_IDX_CTRL_CH3:
      begin
        w[`TDL_CTRL_ON_BIT] = ch[1].on;
        w[`TDL_CTRL_SEL_LSB +: 2] = ch[1].sel;
      end
      `TDL_IDX_CODE_CH2:
      begin
        w[7:0] = ch[0].code;
      end
      `TDL_IDX_CODE_CH3:
      begin
        w[7:0] = ch[1].code;
      end
      `TDL_IDX_UPPER_CH2:
      begin
        w[7:0] = ch[0].upper;
      end
      `TDL_IDX_UPPER_CH3:
      begin
        w[7:0] = ch[1].upper;
      end
      `TDL_IDX_LOWER_CH2:
      begin
        w[7:0] = ch[0].lower;
      end
      `TDL_IDX_LOWER_CH3:
      begin
        w[7:0] = ch[1].lower;
      end
      `TDL_IDX_STATUS:
      begin
        w[7:0] = stat;
      end
      default:
      begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction

  always_comb
  begin
    next_s = s;
    // A stalled data phase keeps its write pending until hready rises
    next_s.wr_pend = s.wr_pend && !hready_i;
    // Data phase of a write: store the low byte; control bits 7:3 are dropped
    if (s.wr_pend && hready_i)
    begin
      case (s.wr_idx)
        `TDL_IDX_CTRL_CH2:
        begin
          next_s.ch[0].on = hwdata_i[`TDL_CTRL_ON_BIT];
          next_s.ch[0].sel = hwdata_i[`TDL_CTRL_SEL_LSB +: 2];
        end
        `TDL_IDX_CTRL_CH3:
        begin
          next_s.ch[1].on = hwdata_i[`TDL_CTRL_ON_BIT];
          next_s.ch[1].sel = hwdata_i[`TDL_CTRL_SEL_LSB +: 2];
        end
        `TDL_IDX_CODE_CH2:
        begin
          next_s.ch[0].code = hwdata_i[7:0];
        end
        `TDL_IDX_CODE_CH3:
        begin
          next_s.ch[1].code = hwdata_i[7:0];
        end
        `TDL_IDX_UPPER_CH2:
        begin
          next_s.ch[0].upper = hwdata_i[7:0];
        end
        `TDL_IDX_UPPER_CH3:
        begin
          next_s.ch[1].upper = hwdata_i[7:0];
        end
        `TDL_IDX_LOWER_CH2:
        begin
          next_s.ch[0].lower = hwdata_i[7:0];
        end
        `TDL_IDX_LOWER_CH3:
        begin
          next_s.ch[1].lower = hwdata_i[7:0];
        end
        default:
        begin
          next_s.ch = s.ch;
        end
      endcase
    end
    // Address phase: decoded from next_s so a read right after a write sees the new value
    if (take)
    begin
      next_s.wr_pend = hwrite_i;
      next_s.wr_idx = addr_idx;
      if (!hwrite_i)
      begin
        next_s.rdata = read_word(addr_idx, next_s.ch, status);
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        s.ch[c].on <= 1'b0;
        s.ch[c].sel <= `TDL_RST_SEL;
        s.ch[c].code <= `TDL_RST_CODE;
        s.ch[c].upper <= `TDL_RST_UPPER;
        s.ch[c].lower <= `TDL_RST_LOWER;
      end
      s.wr_pend <= 1'b0;
      s.wr_idx <= 8'h00;
      s.rdata <= 32'h0;
    end
    else
    begin
      s <= next_s;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    tdl_channel u_chan
    (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .cfg_i(s.ch[g]),
      .code_o(code[g]),
      .drive_o(drive[g]),
      .mid_mv_o(mid_mv[g]),
      .clamp_hi_o(clamp_hi[g]),
      .clamp_lo_o(clamp_lo[g])
    );
  end

  // Zero wait state slave, always OKAY
  assign hrdata_o = s.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign ch2_code_o = code[0];
  assign ch2_drive_o = drive[0];
  assign ch2_mid_mv_o = mid_mv[0];
  assign ch3_code_o = code[1];
  assign ch3_drive_o = drive[1];
  assign ch3_mid_mv_o = mid_mv[1];
endmodule

// file: tb/tdl_regs_props.sv
// Channel 2 checker for the trim DAC register bank
`timescale 1ns/1ps
module tdl_regs_props (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic [7:0] ch2_code_o,
  input wire logic ch2_drive_o,
  input wire logic [10:0] ch2_mid_mv_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Shadow rebuilt from bus traffic; ok waits one edge so $past is clean
  logic ok, wp, rp, en;
  logic [7:0] ix, ct, cd, hi, lo, ex;
  logic [10:0] mv;
  assign ex = cd > hi ? hi : (cd < lo ? lo : cd);
  assign mv = ct[1] ? (ct[0] ? 11'd600 : 11'd800) : (ct[0] ? 11'd1000 : 11'd1250);
  assign en = ct[2] && lo <= hi;
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      {ok, wp, rp, ix, ct, cd, hi, lo} <= {3'h0, 16'h0, 24'h7fff00};
    else
    begin
      ok <= 1'b1;
      if (hready_i)
      begin
        wp <= hsel_i && htrans_i[1] && hwrite_i;
        rp <= hsel_i && htrans_i[1] && !hwrite_i;
        ix <= haddr_i[9:2];
      end
      if (wp && hready_i)
        case (ix)
          8'h51: ct <= hwdata_i[7:0] & 8'h07;
          8'h59: cd <= hwdata_i[7:0];
          8'h61: hi <= hwdata_i[7:0];
          8'h69: lo <= hwdata_i[7:0];
          default: ;
        endcase
    end
  a_code_clamp: assert property (ok |-> ch2_code_o == $past(ex))
    else $error("applied code wrong");
  a_drive_rule: assert property (ok |-> ch2_drive_o == $past(en))
    else $error("drive wrong");
  a_mid_level: assert property (ok |-> ch2_mid_mv_o == $past(mv))
    else $error("midcode level wrong");
  a_crossed_off: assert property ((lo > hi) [*2] |-> !ch2_drive_o)
    else $error("driven with crossed limits");
  a_code_read: assert property (rp && ix == 8'h59 |-> hrdata_o == {24'h0, cd})
    else $error("code readback wrong");
  a_ctrl_read: assert property (rp && ix == 8'h51 |-> hrdata_o == {24'h0, ct})
    else $error("control readback wrong");
  a_upper_read: assert property (rp && ix == 8'h61 |-> hrdata_o == {24'h0, hi})
    else $error("upper readback wrong");
  a_lower_read: assert property (rp && ix == 8'h69 |-> hrdata_o == {24'h0, lo})
    else $error("lower readback wrong");
  c_clamp_hi: cover property (ct[2] && cd > hi);
  c_clamp_lo: cover property (cd < lo && lo <= hi);
  c_crossed: cover property (ct[2] && lo > hi);
endmodule
bind tdl_regs tdl_regs_props tdl_regs_props_inst
(
  .clock_i(clock_i),
  .nrst_i(nrst_i),
  .hsel_i(hsel_i),
  .haddr_i(haddr_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hwdata_i(hwdata_i),
  .hrdata_o(hrdata_o),
  .ch2_code_o(ch2_code_o),
  .ch2_drive_o(ch2_drive_o),
  .ch2_mid_mv_o(ch2_mid_mv_o)
);

// file: tb/tdl_regs_tb.sv
// Self-checking bench for the trim DAC register bank
`timescale 1ns/1ps
module tdl_regs_tb;
  logic clock_i = 0, nrst_i = 0, hsel_i = 0, hwrite_i = 0, hready_i;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rv;
  logic [1:0] htrans_i = 0;
  logic [2:0] hsize_i = 3'h2;
  logic hreadyout_o, hresp_o, ch2_drive_o, ch3_drive_o;
  logic [7:0] ch2_code_o, ch3_code_o;
  logic [10:0] ch2_mid_mv_o, ch3_mid_mv_o;
  logic [10:0] mvt [4] = '{11'd1250, 11'd1000, 11'd800, 11'd600};
  // Index, value, expected code, expected drive
  logic [31:0] tbl [8] = '{32'h61907f01, 32'h59c09001, 32'h59909001, 32'h69409001,
    32'h59204001, 32'h59404001, 32'h69a0a000, 32'h69004001};
  int miscompares = 0, comparisons = 0;
  assign hready_i = hreadyout_o;
  tdl_regs tdl_regs_inst
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .ch2_code_o(ch2_code_o),
    .ch2_drive_o(ch2_drive_o),
    .ch2_mid_mv_o(ch2_mid_mv_o),
    .ch3_code_o(ch3_code_o),
    .ch3_drive_o(ch3_drive_o),
    .ch3_mid_mv_o(ch3_mid_mv_o)
  );
  initial
  begin
    forever #2 clock_i = ~clock_i;
  end
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wt;
    int n;
    n = 0;
    @(posedge clock_i);
    while (hready_i !== 1'b1)
    begin
      if (++n > 20)
      begin
        miscompares++;
        wrap_up;
      end
      @(posedge clock_i);
    end
  endtask
  // One whole-word transfer; read data taken at the data phase edge
  task xf(input logic w, input logic [7:0] i, input logic [7:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    haddr_i <= {22'h0, i, 2'b00};
    wt;
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= {24'h0, d};
    wt;
    rv = hrdata_o;
  endtask
  task rd(input logic [7:0] i, input logic [31:0] e);
    xf(1'b0, i, 8'h0);
    chk(rv, e);
    chk(32'(hresp_o), 32'h0);
  endtask
  task t_reset;
    rd(8'h51, 32'h0);
    rd(8'h59, 32'h7f);
    rd(8'h61, 32'hff);
    rd(8'h69, 32'h0);
    chk(32'(ch2_code_o), 32'h7f);
    chk(32'(ch2_mid_mv_o), 32'd1250);
    chk(32'(ch2_drive_o), 32'h0);
  endtask
  task t_sel;
    for (int s = 0; s < 4; s++)
    begin
      xf(1'b1, 8'h51, 8'hfc | 8'(s));
      rd(8'h51, 32'h4 | s);
      repeat (2) @(posedge clock_i);
      chk(32'(ch2_mid_mv_o), 32'(mvt[s]));
      chk(32'(ch2_drive_o), 32'h1);
    end
  endtask
  task t_clamp;
    for (int k = 0; k < 8; k++)
    begin
      xf(1'b1, tbl[k][31:24], tbl[k][23:16]);
      repeat (2) @(posedge clock_i);
      chk(32'(ch2_code_o), 32'(tbl[k][15:8]));
      chk(32'(ch2_drive_o), 32'(tbl[k][0]));
    end
  endtask
  task t_ch3;
    xf(1'b1, 8'h5a, 8'h33);
    rd(8'h5a, 32'h33);
    rd(8'h40, 32'h0);
    xf(1'b1, 8'h52, 8'h05);
    xf(1'b1, 8'h62, 8'h30);
    repeat (2) @(posedge clock_i);
    chk(32'(ch3_code_o), 32'h30);
    chk(32'(ch3_drive_o), 32'h1);
    chk(32'(ch3_mid_mv_o), 32'd1000);
    xf(1'b1, 8'h6a, 8'h31);
    repeat (2) @(posedge clock_i);
    chk(32'(ch3_drive_o), 32'h0);
    // Status: ch2 driven, ch3 off and clamped high
    rd(8'h70, 32'h21);
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_reset;
    t_sel;
    t_clamp;
    t_ch3;
    wrap_up;
  end
endmodule
